// [verilog/fpes_top.sv]
/*
 * Flash program/erase sequencer: control bits, block protect register,
 * page address latch and read recovery timer, all over AXI4-Lite.
 * Assumes the flash macro consumes the control outputs and that the test
 * voltage detector on the interrupt pin arrives synchronous to sys_clk_i.
 */
// Operation
// - Erase and program selects never both one
// - Erase select bit readable, writable, chooses erase
// - Pages are 64 aligned bytes, singly erasable
// - 48-byte vector area is one page
// - Any flash write latches target page (code: only while a select is set and voltage is off)
// - Array readable after recovery time
// - Protected range blocks high voltage enable
// - All zeros protect all, ones none
// - Non-open protect register locks itself (code: any write with the test voltage present is taken)
// - Mass erase disabled when any protected
// - Protect register changes need test voltage
module fpes_top
    import fpes_pkg::*;
#(
    parameter int RCV_CYC = FPES_RCV_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        flash_wr_i,
    input  wire logic [15:0] flash_addr_i,
    input  wire logic        test_high_voltage_i,
    output logic             erase_sel_o,
    output logic             program_select_o,
    output logic             mass_sel_o,
    output logic             high_voltage_enable_o,
    output logic [15:0]      page_base_o,
    output logic [5:0]       page_len_m1_o,
    output logic             read_ready_o
);
    // Recovery counter is 12 bits wide; refuse what it cannot hold
    if (RCV_CYC < 1 || RCV_CYC > 4095) begin : g_bad_rcv
        $error("RCV_CYC out of range");
    end

    typedef enum logic [2:0] {
        FPES_ST_IDLE = 3'b001,
        FPES_ST_HV   = 3'b010,
        FPES_ST_RCV  = 3'b100
    } fpes_state_e;

    fpes_state_e  st_q, st_d;
    logic         erase_q, prog_q, mass_q, hv_q;
    logic [7:0]   bpr_q;
    logic [15:0]  page_q;
    logic [5:0]   len_q;
    logic         latched_q;
    logic [11:0]  rcv_q;
    logic         aw_q, w_q, bvalid_q, arrdy_q, rvalid_q;
    logic [7:0]   awaddr_q, araddr_q;
    logic [31:0]  wdata_q, rdata_q;
    logic [1:0]   bresp_q, rresp_q;

    // Decode helper used by both read and write paths
    function automatic logic fpes_hit(input logic [7:0] a, input logic [7:0] ofs);
        fpes_hit = (a[7:2] == ofs[7:2]);
    endfunction : fpes_hit

    // Write path: capture address and data in either order
    logic       wdata_q_strb0;
    logic [3:0] wstrb_q;
    logic wr_go, wr_ctrl, wr_bpr, wr_map;
    assign wdata_q_strb0 = wstrb_q[0];
    assign wr_go   = aw_q && w_q && !bvalid_q;
    assign wr_ctrl = wr_go && fpes_hit(awaddr_q, FPES_CTRL_OFS) && wdata_q_strb0;
    assign wr_bpr  = wr_go && fpes_hit(awaddr_q, FPES_BPR_OFS) && wdata_q_strb0;
    assign wr_map  = fpes_hit(awaddr_q, FPES_CTRL_OFS) || fpes_hit(awaddr_q, FPES_BPR_OFS)
                   || fpes_hit(awaddr_q, FPES_LATCH_OFS) || fpes_hit(awaddr_q, FPES_STATUS_OFS);

    // Protection of the latched page against the protect register range
    logic page_prot;
    fpes_protect u_prot (
        .bpr_i  (bpr_q),
        .addr_i (page_q),
        .prot_o (page_prot)
    );

    // Requested control bits after the select interlock
    logic req_erase, req_prog, req_mass, req_hv, hv_ok, erase_n, prog_n;
    assign req_erase = wdata_q[FPES_ERASE_BIT];
    assign req_prog  = wdata_q[FPES_PROG_BIT];
    assign req_mass  = wdata_q[FPES_MASS_BIT];
    assign req_hv    = wdata_q[FPES_HV_BIT];
    // A set of one select is refused while the other is set or set alongside
    assign erase_n   = req_erase && !req_prog && !prog_q;
    assign prog_n    = req_prog && !req_erase && !erase_q;
    // Voltage only on an unprotected page; mass needs an open register
    assign hv_ok     = latched_q && (erase_n || prog_n) && !page_prot
                     && !(req_mass && bpr_q != FPES_BPR_OPEN);

    // Page latch: 64-byte page, or the 48-byte vector area as one page
    logic        vec_hit;
    logic [15:0] pbase;
    assign vec_hit = flash_addr_i >= FPES_VEC_BASE;
    assign pbase   = vec_hit ? FPES_VEC_BASE : {flash_addr_i[15:6], 6'h00};

    // Protect register writes need only the test voltage, whatever the register holds
    logic bpr_wr_ok;
    assign bpr_wr_ok = wr_bpr && test_high_voltage_i;

    // Bus handshake registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= 2'b00;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && !aw_q) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && !w_q) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_map ? 2'b00 : 2'b10;
            end
            if (bvalid_q && s_axi_bready_i) begin
                bvalid_q <= 1'b0;
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
            end
        end
    end

    // Control bits; reset drops every high-voltage operation
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            {hv_q, mass_q, erase_q, prog_q} <= FPES_CTRL_RST;
        end else if (wr_ctrl) begin
            erase_q <= erase_n;
            prog_q  <= prog_n;
            mass_q  <= req_mass && (bpr_q == FPES_BPR_OPEN);
            hv_q    <= req_hv && (hv_q || hv_ok);
        end
    end

    // Protect register and page latch
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bpr_q     <= FPES_BPR_RST;
            page_q    <= 16'h0000;
            len_q     <= 6'h00;
            latched_q <= 1'b0;
        end else begin
            if (bpr_wr_ok) begin
                bpr_q <= wdata_q[7:0];
            end
            if (flash_wr_i && (erase_q || prog_q) && !hv_q) begin
                page_q    <= pbase;
                len_q     <= vec_hit ? 6'(FPES_VEC_BYTES - 1) : 6'(FPES_PAGE_BYTES - 1);
                latched_q <= 1'b1;
            end else if (!erase_q && !prog_q && !hv_q) begin
                latched_q <= 1'b0;
            end
        end
    end

    // Sequencer: track voltage and the read recovery after it drops
    always_comb begin
        st_d = st_q;
        case (st_q)
            FPES_ST_IDLE: if (hv_q) st_d = FPES_ST_HV;
            FPES_ST_HV:   if (!hv_q) st_d = FPES_ST_RCV;
            FPES_ST_RCV:  if (hv_q) st_d = FPES_ST_HV;
                          else if (rcv_q == 12'h000) st_d = FPES_ST_IDLE;
            default:      st_d = FPES_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q  <= FPES_ST_IDLE;
            rcv_q <= 12'h000;
        end else begin
            st_q  <= st_d;
            rcv_q <= (st_q == FPES_ST_HV) ? 12'(RCV_CYC - 1) :
                     (rcv_q != 12'h000) ? rcv_q - 12'h001 : 12'h000;
        end
    end

    // Read path: one read at a time, decoded status
    logic [31:0] rd_w;
    logic        rd_map;
    assign rd_map = fpes_hit(araddr_q, FPES_CTRL_OFS) || fpes_hit(araddr_q, FPES_BPR_OFS)
                  || fpes_hit(araddr_q, FPES_LATCH_OFS) || fpes_hit(araddr_q, FPES_STATUS_OFS);
    assign rd_w = fpes_hit(araddr_q, FPES_CTRL_OFS)   ? {28'h0, hv_q, mass_q, erase_q, prog_q} :
                  fpes_hit(araddr_q, FPES_BPR_OFS)    ? {24'h0, bpr_q} :
                  fpes_hit(araddr_q, FPES_LATCH_OFS)  ? {10'h0, len_q, page_q} :
                  fpes_hit(araddr_q, FPES_STATUS_OFS) ? {29'h0, latched_q, page_prot,
                                                         st_q == FPES_ST_IDLE} :
                  32'h0000_0000;

    logic ar_have_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ar_have_q <= 1'b0;
            araddr_q  <= 8'h00;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= 2'b00;
        end else begin
            if (s_axi_arvalid_i && !ar_have_q && !rvalid_q) begin
                ar_have_q <= 1'b1;
                araddr_q  <= s_axi_araddr_i;
            end
            if (ar_have_q && !rvalid_q) begin
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_w;
                rresp_q   <= rd_map ? 2'b00 : 2'b10;
                ar_have_q <= 1'b0;
            end
            if (rvalid_q && s_axi_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready_o       = !aw_q;
    assign s_axi_wready_o        = !w_q;
    assign s_axi_bvalid_o        = bvalid_q;
    assign s_axi_bresp_o         = bresp_q;
    assign s_axi_arready_o       = !ar_have_q && !rvalid_q;
    assign s_axi_rvalid_o        = rvalid_q;
    assign s_axi_rdata_o         = rdata_q;
    assign s_axi_rresp_o         = rresp_q;
    assign erase_sel_o           = erase_q;
    assign program_select_o      = prog_q;
    assign mass_sel_o            = mass_q;
    assign high_voltage_enable_o = hv_q;
    assign page_base_o           = page_q;
    assign page_len_m1_o         = len_q;
    // One-hot idle bit is a flop itself, so the output needs no decode
    assign read_ready_o          = st_q[0];

    // Checks; reset one is written forward so the first edge sees no stale past
    a_sel_excl: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !(erase_q && prog_q)) else $error("both selects set");
    a_hv_prot: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(hv_q) |-> !page_prot) else $error("voltage on protected page");
    a_mass_lock: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        mass_q |-> bpr_q == FPES_BPR_OPEN) else $error("mass with protection");
    a_bpr_tst: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $changed(bpr_q) |-> $past(test_high_voltage_i)) else $error("protect w/o voltage");
    a_reset_clr: assert property (@(posedge sys_clk_i)
        rst_i |=> !hv_q && !erase_q && !prog_q) else $error("ctrl after reset");
    a_rcv_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(hv_q) |-> !read_ready_o) else $error("ready too early");
    a_hv_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(hv_q) |-> $past(latched_q)) else $error("voltage without latch");
    a_page_align: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        latched_q && page_q != FPES_VEC_BASE |-> page_q[5:0] == 6'h00)
        else $error("page misaligned");
    c_erase: cover property (@(posedge sys_clk_i) erase_q && hv_q);
    c_prog: cover property (@(posedge sys_clk_i) prog_q && hv_q);
    c_rcv: cover property (@(posedge sys_clk_i) $rose(read_ready_o));
endmodule : fpes_top

// [verilog/fpes_pkg.sv]
/*
 * Shared constants for the flash program/erase sequencer: register offsets,
 * control field positions, reset values and the array geometry.
 * Assumes a single 250 MHz clock and an AXI4-Lite register bus.
 */
package fpes_pkg;
    // Register byte offsets
    localparam logic [7:0] FPES_CTRL_OFS    = 8'h00;
    localparam logic [7:0] FPES_BPR_OFS     = 8'h04;
    localparam logic [7:0] FPES_LATCH_OFS   = 8'h08;
    localparam logic [7:0] FPES_STATUS_OFS  = 8'h0c;
    // Control bit positions
    localparam int         FPES_ERASE_BIT   = 1;
    localparam int         FPES_PROG_BIT    = 0;
    localparam int         FPES_MASS_BIT    = 2;
    localparam int         FPES_HV_BIT      = 3;
    // Reset values and protect register settings
    localparam logic [3:0] FPES_CTRL_RST    = 4'h0;
    localparam logic [7:0] FPES_BPR_RST     = 8'hff;
    localparam logic [7:0] FPES_BPR_OPEN    = 8'hff;
    localparam logic [7:0] FPES_BPR_ALL     = 8'h00;
    // Geometry and timing
    localparam int         FPES_PAGE_BYTES  = 64;
    localparam int         FPES_VEC_BYTES   = 48;
    localparam logic [15:0] FPES_VEC_BASE   = 16'hffd0;
    localparam logic [15:0] FPES_TOP_ADDR   = 16'hffff;
    localparam int         FPES_CLK_MHZ     = 250;
    localparam int         FPES_RCV_NS      = 1000;
    localparam int         FPES_RCV_CYC     = (FPES_RCV_NS * FPES_CLK_MHZ) / 1000;
endpackage : fpes_pkg

// [verilog/fpes_protect.sv]
/*
 * Protection checker: decides whether a flash address lies in the protected
 * range set by the block protect register. Purely combinational.
 * Assumes the protected range runs from 0x8000 + bpr * 64 up to the top address.
 */
module fpes_protect
    import fpes_pkg::*;
(
    input  wire logic [7:0]  bpr_i,
    input  wire logic [15:0] addr_i,
    output logic             prot_o
);
    logic [15:0] start_w;

    // Start address: bpr selects a 64-byte boundary in the upper half;
    // built by concatenation, since a shift would drop the fixed top bit
    assign start_w = {2'b10, bpr_i, 6'h00};
    // All ones leaves everything open, all zeros protects all
    assign prot_o  = (bpr_i == FPES_BPR_ALL) ? 1'b1 :
                     (bpr_i == FPES_BPR_OPEN) ? 1'b0 :
                     (addr_i >= start_w);
endmodule : fpes_protect

// [sim/fpes_top_tb.sv]
/*
 * Self-checking bench for fpes_top: AXI4-Lite register traffic, flash writes,
 * protection and reset scenarios, each judged inside its own task.
 * Assumes the assertions live in the design files and one 250 MHz clock.
 */
module fpes_top_tb import fpes_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RCV = 4;  // Short recovery count keeps the run brief
    logic        sys_clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, flash_wr, thv;
    logic        erase, prog, mass, hv, rdy;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, last_rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, last_resp;
    logic [15:0] flash_addr, page_base;
    logic [5:0]  page_len;
    int          num_errors, n_compared;

    fpes_top #(.RCV_CYC(RCV)) u_dut (
        .sys_clk_i(sys_clk), .rst_i(rst),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .flash_wr_i(flash_wr), .flash_addr_i(flash_addr), .test_high_voltage_i(thv),
        .erase_sel_o(erase), .program_select_o(prog), .mass_sel_o(mass),
        .high_voltage_enable_o(hv), .page_base_o(page_base),
        .page_len_m1_o(page_len), .read_ready_o(rdy)
    );

    // Free-running 4 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Write: address and data offered together, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                last_resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            num_errors++;
            end_sim();
        end
        @(posedge sys_clk);  // Keeps the next strobe out of this time step
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                last_rd = rdata;
                last_resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            num_errors++;
            end_sim();
        end
        @(posedge sys_clk);
    endtask : rd

    // CPU store into the array; latches the target page while a select is set and voltage is off
    task automatic fwrite(input logic [15:0] a);
        flash_addr <= a;
        flash_wr <= 1'b1;
        @(posedge sys_clk);
        flash_wr <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask : fwrite

    task automatic set_bpr(input logic [7:0] v);
        thv <= 1'b1;
        wr(FPES_BPR_OFS, {24'h0, v});
        thv <= 1'b0;
    endtask : set_bpr

    task automatic t_reset_vals();
        check({hv, mass, erase, prog}, 32'h0);
        check(rdy, 1'b1);
        rd(FPES_BPR_OFS);
        check(last_rd, {24'h0, FPES_BPR_OPEN});
        rd(FPES_CTRL_OFS);
        check(last_rd, 32'h0);
    endtask : t_reset_vals

    task automatic t_interlock();
        wr(FPES_CTRL_OFS, 32'h3);
        check(erase & prog, 1'b0);
        wr(FPES_CTRL_OFS, 32'h2);
        rd(FPES_CTRL_OFS);
        check(last_rd, 32'h2);
        wr(FPES_CTRL_OFS, 32'h3);
        check(erase & prog, 1'b0);
        wr(FPES_CTRL_OFS, 32'h2);
        wr(FPES_CTRL_OFS, 32'h1);
        check({erase, prog}, 2'b00);
        wr(FPES_CTRL_OFS, 32'h4);
        check(mass, 1'b1);
        wr(FPES_CTRL_OFS, 32'h0);
        rd(FPES_CTRL_OFS);
        check(last_rd, 32'h0);
    endtask : t_interlock

    // The latch follows array writes while the erase select is set, vector area included
    task automatic t_latch();
        wr(FPES_CTRL_OFS, 32'h2);
        fwrite(16'h8a47);
        check({page_len, page_base}, {6'd63, 16'h8a40});
        rd(FPES_LATCH_OFS);
        check(last_rd, 32'h003f_8a40);
        fwrite(16'h8a80);
        check(page_base, 16'h8a80);
        fwrite(16'hffd5);
        rd(FPES_LATCH_OFS);
        check(last_rd, 32'h002f_ffd0);
        wr(FPES_CTRL_OFS, 32'h0);
    endtask : t_latch

    // Full page erase, then read recovery after the voltage drops
    // Step waits are scaled down: the sequencer times only the read recovery, the rest is left to software
    task automatic t_erase();
        int n;
        wr(FPES_CTRL_OFS, 32'h2);
        rd(FPES_BPR_OFS);
        fwrite(16'h8a47);
        repeat (8) @(posedge sys_clk);
        wr(FPES_CTRL_OFS, 32'ha);
        check(hv, 1'b1);
        check(rdy, 1'b0);
        repeat (8) @(posedge sys_clk);
        wr(FPES_CTRL_OFS, 32'h8);
        repeat (4) @(posedge sys_clk);
        wr(FPES_CTRL_OFS, 32'h0);
        for (n = 0; n < RCV + 4 && rdy !== 1'b1; n++) @(posedge sys_clk);
        check(rdy, 1'b1);
    endtask : t_erase

    // Row program: bytes written under voltage leave the page latch alone
    task automatic t_program();
        wr(FPES_CTRL_OFS, 32'h1);
        rd(FPES_BPR_OFS);
        fwrite(16'h8b10);
        repeat (8) @(posedge sys_clk);
        wr(FPES_CTRL_OFS, 32'h9);
        check({hv, prog, erase}, 3'b110);
        fwrite(16'h8b11);
        repeat (8) @(posedge sys_clk);
        check(page_base, 16'h8b00);
        wr(FPES_CTRL_OFS, 32'h8);
        check({hv, prog}, 2'b10);
        wr(FPES_CTRL_OFS, 32'h0);
        check(hv, 1'b0);
    endtask : t_program

    // Reset in the middle of a program step
    task automatic t_midreset();
        wr(FPES_CTRL_OFS, 32'h1);
        rd(FPES_BPR_OFS);
        fwrite(16'h8b10);
        wr(FPES_CTRL_OFS, 32'h9);
        check({hv, prog}, 2'b11);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        check({hv, mass, erase, prog}, 32'h0);
        rd(FPES_CTRL_OFS);
        check(last_rd, 32'h0);
    endtask : t_midreset

    // Protected range starts at 0x8000 + 0x80 * 64 = 0xa000
    task automatic t_protect();
        wr(FPES_BPR_OFS, 32'h80);
        rd(FPES_BPR_OFS);
        check(last_rd, 32'hff);
        set_bpr(8'h80);
        rd(FPES_BPR_OFS);
        check(last_rd, 32'h80);
        wr(FPES_BPR_OFS, 32'hff);
        rd(FPES_BPR_OFS);
        check(last_rd, 32'h80);
        wr(FPES_CTRL_OFS, 32'h2);
        rd(FPES_BPR_OFS);
        fwrite(16'ha000);
        wr(FPES_CTRL_OFS, 32'ha);
        check(hv, 1'b0);
        fwrite(16'h9fc0);
        wr(FPES_CTRL_OFS, 32'ha);
        check(hv, 1'b1);
        wr(FPES_CTRL_OFS, 32'h8);
        wr(FPES_CTRL_OFS, 32'h0);
        wr(FPES_CTRL_OFS, 32'h6);
        check(mass, 1'b0);
        fwrite(16'h9fc0);
        wr(FPES_CTRL_OFS, 32'he);
        check(hv, 1'b0);
        wr(FPES_CTRL_OFS, 32'h0);
        set_bpr(8'h00);
        wr(FPES_CTRL_OFS, 32'h2);
        rd(FPES_BPR_OFS);
        fwrite(16'h8000);
        wr(FPES_CTRL_OFS, 32'ha);
        check(hv, 1'b0);
        wr(FPES_CTRL_OFS, 32'h0);
    endtask : t_protect

    task automatic t_unmapped();
        rd(8'h10);
        check(last_resp, 2'b10);
        wr(8'h14, 32'h5);
        check(last_resp, 2'b10);
    endtask : t_unmapped

    // Main sequence: 20-cycle reset, then each scenario in turn
    initial begin
        num_errors = 0;
        n_compared = 0;
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, flash_wr, thv} = 7'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        flash_addr = 16'h0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset_vals();
        t_interlock();
        t_latch();
        t_erase();
        t_program();
        t_midreset();
        t_protect();
        t_unmapped();
        end_sim();
    end
endmodule : fpes_top_tb
